// ==== dv/pmc_mem_model.sv ====
// memory responder model for the counter update port
`timescale 1ns/10ps
module pmc_mem_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// pacing of answers
	input wire logic slow_i,
	// memory port
	input wire logic mem_req_i,
	input wire logic mem_we_i,
	input wire logic [31:0] mem_addr_i,
	input wire logic [63:0] mem_wdata_i,
	output logic mem_ack_o,
	output logic [63:0] mem_rdata_o
);
	logic [63:0] mem_q [0:15];
	logic [1:0] wait_q;
	// ----------------------------------------
	// preload: base pointer slots, per-cpu quadwords
	// ----------------------------------------
	initial begin
		foreach (mem_q[k]) mem_q[k] = 64'h0;
		mem_q[4] = 64'h0000_0001_0000_fff0;
		mem_q[5] = 64'h0000_0000_0000_0005;
		mem_q[11] = 64'h0000_0000_0000_0403;
		mem_q[12] = 64'h0000_0000_0000_0401;
	end
	// ----------------------------------------
	// single-beat answer, one gap cycle after each, four when slow
	// ----------------------------------------
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mem_ack_o <= 1'b0;
			wait_q <= 2'h0;
			mem_rdata_o <= 64'h0;
		end else begin
			mem_ack_o <= 1'b0;
			// data not held once the answer is gone
			mem_rdata_o <= ~mem_rdata_o;
			if (mem_req_i && !mem_ack_o) begin
				if (wait_q >= (slow_i ? 2'h3 : 2'h0)) begin
					mem_ack_o <= 1'b1;
					wait_q <= 2'h0;
					mem_rdata_o <= mem_q[mem_addr_i[6:3]];
					if (mem_we_i)
						mem_q[mem_addr_i[6:3]] <= mem_wdata_i;
				end else begin
					wait_q <= wait_q + 2'h1;
				end
			end
		end
	end
endmodule

// ==== dv/test_pmc_top.sv ====
// self-checking bench for the performance monitor counters
`timescale 1ns/10ps
module test_pmc_top;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [1:0] unit = 2'h0;
	logic [2:0] code = 3'h0;
	logic [12:0] ev = 13'h0;
	logic ctl_wr = 1'b0, ctl_on = 1'b0, clr = 1'b0;
	logic me_wr = 1'b0, me_d = 1'b0, ctx_ld = 1'b0, ctx_bit = 1'b0;
	logic [4:0] prio = 5'h1f;
	logic bnd = 1'b0, slow = 1'b0, seen;
	logic [31:0] ctl_blk = 32'h0000_0100;
	logic fac_on, irq, busy, mchk, mem_req, mem_we, mem_ack;
	logic [31:0] rdo, maddr;
	logic [4:0] irql;
	logic [7:0] mcode;
	logic [63:0] mwd, mrd;
	logic [15:0] ea, eb;
	logic [1:0] inc;
	int fail_count = 0;
	int n_compared = 0;
	int cycles = 0;
	always #25 clk_i = ~clk_i;
	pmc_top i_pmc_top (.clk_i(clk_i), .nrst_i(nrst_i),
		.source_unit_select_i(unit), .exec_event_select_i(code),
		.virtual_icache_access_i(ev[0]), .virtual_icache_hit_i(ev[1]),
		.cycle_i(ev[2]),
		.s3_stall_i(ev[3]), .empa_stall_i(ev[4]), .retire_i(ev[5]),
		.total_stall_i(ev[6]), .s5_bump_i(ev[7]), .readout_wr_i(ev[8]),
		.mem_inc_a_i(ev[9]), .mem_inc_b_i(ev[10]),
		.cache_inc_a_i(ev[11]), .cache_inc_b_i(ev[12]),
		.exec_control_reg_wr_i(ctl_wr), .exec_control_reg_on_i(ctl_on),
		.counter_clear_bit_i(clr), .me_wr_i(me_wr), .me_wdata_i(me_d),
		.ctx_load_i(ctx_ld), .ctx_monitor_enable_bit_i(ctx_bit),
		.priority_level_i(prio), .instr_boundary_i(bnd),
		.processor_number_i(8'h02), .system_control_block_i(ctl_blk),
		.facility_on_o(fac_on), .counter_readout_reg_o(rdo), .irq_o(irq),
		.irq_level_o(irql), .busy_o(busy), .mchk_o(mchk),
		.mchk_code_o(mcode), .mem_req_o(mem_req), .mem_we_o(mem_we),
		.mem_addr_o(maddr), .mem_wdata_o(mwd), .mem_ack_i(mem_ack),
		.mem_rdata_i(mrd));
	pmc_mem_model i_pmc_mem_model (.clk_i(clk_i), .nrst_i(nrst_i),
		.slow_i(slow), .mem_req_i(mem_req), .mem_we_i(mem_we),
		.mem_addr_i(maddr), .mem_wdata_i(mwd), .mem_ack_o(mem_ack),
		.mem_rdata_o(mrd));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task chk(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task finish_test;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task wait_idle;
		int k;
		cyc(2);
		k = 0;
		while (busy === 1'b1 && k < 300) begin
			cyc(1);
			k++;
		end
		chk(64'(busy), 64'h0);
	endtask
	// expected {inc_b, inc_a} for one cycle of events
	function logic [1:0] exp_inc(input logic [1:0] u, input logic [2:0] c,
		input logic [12:0] e);
		logic a, b;
		a = 1'b0;
		b = 1'b0;
		case (u)
			2'h0: {a, b} = {e[0], e[1]};
			2'h1: case (c)
				3'h0: {a, b} = {e[2], e[3]};
				3'h1: {a, b} = {e[2], e[4]};
				3'h2: {a, b} = {e[2], e[5]};
				3'h3: {a, b} = {e[2], e[6]};
				3'h4: {a, b} = {e[6], e[3]};
				3'h5: {a, b} = {e[6], e[4]};
				3'h7: {a, b} = {e[7] | e[8], e[7] | e[8]};
				default: {a, b} = 2'h0;
			endcase
			2'h2: {a, b} = {e[9], e[10]};
			default: {a, b} = {e[11], e[12]};
		endcase
		return {a & b, a};
	endfunction
	// selection chosen before enabling, then a varied event stream
	task sel_case(input logic [1:0] u, input logic [2:0] c);
		int i;
		unit = u;
		code = c;
		clr = 1'b1;
		ea = 16'h0;
		eb = 16'h0;
		cyc(1);
		clr = 1'b0;
		ctl_wr = 1'b1;
		ctl_on = 1'b1;
		cyc(1);
		ctl_wr = 1'b0;
		for (i = 0; i < 16; i++) begin
			ev = {i[3:0], ~i[3:0], i[3:0] ^ 4'h5, i[1]};
			inc = exp_inc(u, c, ev);
			ea += 16'(inc[0]);
			eb += 16'(inc[1]);
			cyc(1);
		end
		ev = 13'h0;
		ctl_wr = 1'b1;
		ctl_on = 1'b0;
		cyc(1);
		ctl_wr = 1'b0;
		ev = '1;
		cyc(2);
		ev = 13'h0;
		cyc(1);
		chk(64'(rdo), 64'({eb, ea}));
		chk(64'({busy, fac_on}), 64'h0);
	endtask
	// ----------------------------------------
	// hang guard
	// ----------------------------------------
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 80000) begin
			fail_count++;
			finish_test;
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		cyc(10);
		nrst_i = 1'b1;
		cyc(1);
		chk(64'(rdo), 64'h0);
		chk(64'({fac_on, irq, busy}), 64'h0);
		chk(64'(irql), 64'h1b);
		for (int u = 0; u < 4; u++)
			for (int c = 0; c < 8; c++)
				if (u == 1 || c == 0)
					sel_case(u[1:0], c[2:0]);
		// saturate counter a while priority blocks service
		unit = 2'h1;
		code = 3'h3;
		clr = 1'b1;
		cyc(1);
		clr = 1'b0;
		ctl_wr = 1'b1;
		ctl_on = 1'b1;
		cyc(1);
		ctl_wr = 1'b0;
		ev = 13'h0044;
		cyc(100);
		ev = 13'h0004;
		cyc(65445);
		ev = 13'h0;
		chk(64'(rdo), 64'h0064_ffff);
		chk(64'(irq), 64'h1);
		chk(64'({fac_on, busy}), 64'h2);
		prio = 5'h10;
		cyc(5);
		chk(64'(busy), 64'h0);
		bnd = 1'b1;
		wait_idle;
		chk(i_pmc_mem_model.mem_q[4], 64'h0000_0001_0001_ffef);
		chk(i_pmc_mem_model.mem_q[5], 64'h0000_0000_0000_0069);
		chk(64'({fac_on, irq}), 64'h2);
		chk(64'(rdo), 64'h0);
		// context load with monitoring off, slow memory
		slow = 1'b1;
		ev = 13'h0004;
		cyc(10);
		ev = 13'h0;
		ctx_ld = 1'b1;
		ctx_bit = 1'b0;
		cyc(1);
		ctx_ld = 1'b0;
		wait_idle;
		chk(i_pmc_mem_model.mem_q[4], 64'h0000_0001_0001_fff9);
		chk(64'({fac_on, rdo}), 64'h0);
		// bad configuration bits in the base pointer slot
		ctl_blk = 32'h0000_0108;
		me_wr = 1'b1;
		me_d = 1'b1;
		cyc(1);
		me_wr = 1'b0;
		chk(64'(fac_on), 64'h1);
		ev = 13'h0004;
		cyc(3);
		ev = 13'h0;
		me_wr = 1'b1;
		me_d = 1'b0;
		cyc(1);
		me_wr = 1'b0;
		seen = 1'b0;
		repeat (40) begin
			cyc(1);
			if (mchk === 1'b1)
				seen = 1'b1;
		end
		chk(64'(seen), 64'h1);
		chk(64'(mcode), 64'h01);
		chk(i_pmc_mem_model.mem_q[4], 64'h0000_0001_0001_fff9);
		chk(64'(busy), 64'h0);
		finish_test;
	end
endmodule

// ==== hdl/pmc_cnt_if.sv ====
// signals between event selection, counters and update control
`timescale 1ns/10ps
interface pmc_cnt_if;
	logic inc_a;
	logic inc_b;
	logic count_en;
	logic clear;
	pmc_pkg::pmc_cnt_t cnt_a;
	pmc_pkg::pmc_cnt_t cnt_b;
	logic half;
	modport sel (output inc_a, output inc_b);
	modport cnt (input inc_a, input inc_b, input count_en, input clear,
		output cnt_a, output cnt_b, output half);
	modport ctl (output count_en, output clear, input cnt_a, input cnt_b,
		input half);
endinterface

// ==== hdl/pmc_counters.sv ====
// two 16-bit event counters with shared clear
`timescale 1ns/10ps
`include "pmc_defs.svh"
module pmc_counters (
	input wire logic clk_i,
	input wire logic nrst_i,
	pmc_cnt_if.cnt cif
);
	pmc_pkg::pmc_cnt_t cnt_q [2];
	logic [1:0] inc;
	logic inhibit;

	assign inhibit = cnt_q[0] == `PMC_CNT_MAX;
	assign inc[0] = cif.inc_a & cif.count_en & ~inhibit;
	assign inc[1] = cif.inc_b & inc[0];

	for (genvar i = 0; i < 2; i++) begin : g_cnt
		always_ff @(posedge clk_i or negedge nrst_i) begin
			if (!nrst_i) begin
				cnt_q[i] <= 16'h0000;
			end else if (cif.clear) begin
				cnt_q[i] <= 16'h0000;
			end else if (inc[i]) begin
				cnt_q[i] <= cnt_q[i] + 16'h0001;
			end
		end
	end

	assign cif.cnt_a = cnt_q[0];
	assign cif.cnt_b = cnt_q[1];
	assign cif.half = cnt_q[0][`PMC_HALF_BIT] | cnt_q[1][`PMC_HALF_BIT];

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	max_hold_a: assert property (
		cnt_q[0] == `PMC_CNT_MAX && !cif.clear ##1 !cif.clear
		|-> cnt_q[0] == `PMC_CNT_MAX && $stable(cnt_q[1]))
		else $error("counters moved past maximum");
	subset_a: assert property (
		!cif.clear && cnt_q[1] != $past(cnt_q[1]) && $past(nrst_i)
		|-> cnt_q[0] != $past(cnt_q[0]))
		else $error("second counter moved without the first");
endmodule

// ==== hdl/pmc_defs.svh ====
// constants of the performance monitor counters
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH
`define PMC_BASE_PTR_OFS 32'h0000_0058
`define PMC_BASE_MASK 32'hffff_fff8
`define PMC_CFG_OK 3'h3
`define PMC_CPU_SHIFT 4'h0
`define PMC_QUAD_STEP 32'h0000_0008
`define PMC_IRQ_LEVEL 5'h1b
`define PMC_CFG_FAULT_CODE 8'h01
`define PMC_CNT_MAX 16'hffff
`define PMC_HALF_BIT 15
`define PMC_SRC_FETCH 2'h0
`define PMC_SRC_EXEC 2'h1
`define PMC_SRC_MEM 2'h2
`define PMC_SRC_CACHE 2'h3
`define PMC_EX_CYC_S3 3'h0
`define PMC_EX_CYC_EMPA 3'h1
`define PMC_EX_CYC_RET 3'h2
`define PMC_EX_CYC_TOT 3'h3
`define PMC_EX_TOT_S3 3'h4
`define PMC_EX_TOT_EMPA 3'h5
`define PMC_EX_BUMP 3'h7
`endif

// ==== hdl/pmc_event_sel.sv ====
// increment source selection for both counters
`timescale 1ns/10ps
`include "pmc_defs.svh"
module pmc_event_sel (
	input wire logic clk_i,
	input wire logic nrst_i,
	// selection
	input wire logic [1:0] source_unit_select_i,
	input wire logic [2:0] exec_event_select_i,
	// events
	input wire logic virtual_icache_access_i,
	input wire logic virtual_icache_hit_i,
	input wire logic cycle_i,
	input wire logic s3_stall_i,
	input wire logic empa_stall_i,
	input wire logic retire_i,
	input wire logic total_stall_i,
	input wire logic s5_bump_i,
	input wire logic readout_wr_i,
	input wire logic mem_inc_a_i,
	input wire logic mem_inc_b_i,
	input wire logic cache_inc_a_i,
	input wire logic cache_inc_b_i,
	// to counters
	pmc_cnt_if.sel cif
);
	logic [1:0] ex_inc;
	logic bump;

	assign bump = s5_bump_i | readout_wr_i;

	function automatic logic [1:0] exec_decode(input logic [2:0] sel);
		case (sel)
			`PMC_EX_CYC_S3: exec_decode = {cycle_i, s3_stall_i};
			`PMC_EX_CYC_EMPA: exec_decode = {cycle_i, empa_stall_i};
			`PMC_EX_CYC_RET: exec_decode = {cycle_i, retire_i};
			`PMC_EX_CYC_TOT: exec_decode = {cycle_i, total_stall_i};
			`PMC_EX_TOT_S3: exec_decode = {total_stall_i, s3_stall_i};
			`PMC_EX_TOT_EMPA: exec_decode = {total_stall_i, empa_stall_i};
			`PMC_EX_BUMP: exec_decode = {bump, bump};
			default: exec_decode = 2'h0;
		endcase
	endfunction

	// the decode reads the event pins, so it must follow them too
	always_comb begin
		ex_inc = exec_decode(exec_event_select_i);
	end

	always_comb begin
		case (source_unit_select_i)
			`PMC_SRC_FETCH: begin
				{cif.inc_a, cif.inc_b} = {virtual_icache_access_i,
					virtual_icache_hit_i};
			end
			`PMC_SRC_EXEC: {cif.inc_a, cif.inc_b} = ex_inc;
			`PMC_SRC_MEM: {cif.inc_a, cif.inc_b} = {mem_inc_a_i, mem_inc_b_i};
			default: {cif.inc_a, cif.inc_b} = {cache_inc_a_i, cache_inc_b_i};
		endcase
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	undef_code_a: assert property (
		source_unit_select_i == `PMC_SRC_EXEC && exec_event_select_i == 3'h6
		|-> !cif.inc_a && !cif.inc_b)
		else $error("undefined exec code produced an increment");
	bump_both_a: assert property (
		source_unit_select_i == `PMC_SRC_EXEC &&
		exec_event_select_i == `PMC_EX_BUMP && readout_wr_i
		|-> cif.inc_a && cif.inc_b)
		else $error("readout write did not bump both counters");
endmodule

// ==== hdl/pmc_pkg.sv ====
// types of the performance monitor counters
package pmc_pkg;
	typedef enum logic [2:0] {
		PMC_IDLE = 3'h0,
		PMC_SNAP = 3'h1,
		PMC_BASE = 3'h3,
		PMC_CHK = 3'h2,
		PMC_RDA = 3'h6,
		PMC_WRA = 3'h7,
		PMC_RDB = 3'h5,
		PMC_WRB = 3'h4
	} pmc_state_t;
	typedef logic [15:0] pmc_cnt_t;
endpackage

// ==== hdl/pmc_top.sv ====
// performance monitor counters with memory update sequencer
`timescale 1ns/10ps
`include "pmc_defs.svh"
module pmc_top (
	input wire logic clk_i,
	input wire logic nrst_i,
	// event selection, chosen before enabling
	input wire logic [1:0] source_unit_select_i,
	input wire logic [2:0] exec_event_select_i,
	// event sources
	input wire logic virtual_icache_access_i,
	input wire logic virtual_icache_hit_i,
	input wire logic cycle_i,
	input wire logic s3_stall_i,
	input wire logic empa_stall_i,
	input wire logic retire_i,
	input wire logic total_stall_i,
	input wire logic s5_bump_i,
	input wire logic mem_inc_a_i,
	input wire logic mem_inc_b_i,
	input wire logic cache_inc_a_i,
	input wire logic cache_inc_b_i,
	// software control
	input wire logic exec_control_reg_wr_i,
	input wire logic exec_control_reg_on_i,
	input wire logic counter_clear_bit_i,
	input wire logic me_wr_i,
	input wire logic me_wdata_i,
	input wire logic readout_wr_i,
	input wire logic ctx_load_i,
	input wire logic ctx_monitor_enable_bit_i,
	// processor state
	input wire logic [4:0] priority_level_i,
	input wire logic instr_boundary_i,
	input wire logic [7:0] processor_number_i,
	input wire logic [31:0] system_control_block_i,
	// status
	output logic facility_on_o,
	output logic [31:0] counter_readout_reg_o,
	output logic irq_o,
	output logic [4:0] irq_level_o,
	output logic busy_o,
	output logic mchk_o,
	output logic [7:0] mchk_code_o,
	// memory port
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [31:0] mem_addr_o,
	output logic [63:0] mem_wdata_o,
	input wire logic mem_ack_i,
	input wire logic [63:0] mem_rdata_i
);
	pmc_cnt_if cif ();
	pmc_pkg::pmc_state_t state_q;
	pmc_pkg::pmc_cnt_t snap_a_q;
	pmc_pkg::pmc_cnt_t snap_b_q;
	logic facility_on_q;
	logic irq_q;
	logic half_q;
	logic cause_irq_q;
	logic mchk_q;
	logic [31:0] lw_q;
	logic [31:0] addr_q;
	logic [63:0] wdata_q;
	logic irq_go;
	logic flush_go;
	logic go;
	logic cfg_ok;
	logic done;
	logic irq_set;
	logic irq_clr;

	pmc_event_sel i_pmc_event_sel (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.source_unit_select_i(source_unit_select_i),
		.exec_event_select_i(exec_event_select_i),
		.virtual_icache_access_i(virtual_icache_access_i),
		.virtual_icache_hit_i(virtual_icache_hit_i),
		.cycle_i(cycle_i),
		.s3_stall_i(s3_stall_i),
		.empa_stall_i(empa_stall_i),
		.retire_i(retire_i),
		.total_stall_i(total_stall_i),
		.s5_bump_i(s5_bump_i),
		.readout_wr_i(readout_wr_i),
		.mem_inc_a_i(mem_inc_a_i),
		.mem_inc_b_i(mem_inc_b_i),
		.cache_inc_a_i(cache_inc_a_i),
		.cache_inc_b_i(cache_inc_b_i),
		.cif(cif.sel)
	);

	pmc_counters i_pmc_counters (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.cif(cif.cnt)
	);

	// ---------------------------------------------------------------
	// triggers
	// ---------------------------------------------------------------
	assign irq_go = irq_q && priority_level_i < `PMC_IRQ_LEVEL &&
		instr_boundary_i;
	assign flush_go = facility_on_q && ((ctx_load_i &&
		!ctx_monitor_enable_bit_i) || (me_wr_i && !me_wdata_i));
	assign go = state_q == pmc_pkg::PMC_IDLE && (irq_go || flush_go);
	assign cfg_ok = lw_q[2:0] == `PMC_CFG_OK;
	assign done = (state_q == pmc_pkg::PMC_WRB && mem_ack_i) ||
		(state_q == pmc_pkg::PMC_CHK && !cfg_ok);

	// ---------------------------------------------------------------
	// update sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_q <= pmc_pkg::PMC_IDLE;
		end else begin
			case (state_q)
				pmc_pkg::PMC_IDLE: begin
					if (go) begin
						state_q <= pmc_pkg::PMC_SNAP;
					end
				end
				pmc_pkg::PMC_SNAP: state_q <= pmc_pkg::PMC_BASE;
				pmc_pkg::PMC_BASE: begin
					if (mem_ack_i) begin
						state_q <= pmc_pkg::PMC_CHK;
					end
				end
				pmc_pkg::PMC_CHK: begin
					state_q <= cfg_ok ? pmc_pkg::PMC_RDA : pmc_pkg::PMC_IDLE;
				end
				pmc_pkg::PMC_RDA: begin
					if (mem_ack_i) begin
						state_q <= pmc_pkg::PMC_WRA;
					end
				end
				pmc_pkg::PMC_WRA: begin
					if (mem_ack_i) begin
						state_q <= pmc_pkg::PMC_RDB;
					end
				end
				pmc_pkg::PMC_RDB: begin
					if (mem_ack_i) begin
						state_q <= pmc_pkg::PMC_WRB;
					end
				end
				pmc_pkg::PMC_WRB: begin
					if (mem_ack_i) begin
						state_q <= pmc_pkg::PMC_IDLE;
					end
				end
				default: state_q <= pmc_pkg::PMC_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cause_irq_q <= 1'b0;
		end else if (go) begin
			cause_irq_q <= irq_go;
		end
	end

	// snapshot taken in the cycle the counters are cleared
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			snap_a_q <= 16'h0000;
			snap_b_q <= 16'h0000;
		end else if (state_q == pmc_pkg::PMC_SNAP) begin
			snap_a_q <= cif.cnt_a;
			snap_b_q <= cif.cnt_b;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lw_q <= 32'h0000_0000;
		end else if (state_q == pmc_pkg::PMC_BASE && mem_ack_i) begin
			lw_q <= mem_rdata_i[31:0];
		end
	end

	// memory address and write data
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			addr_q <= 32'h0000_0000;
		end else if (state_q == pmc_pkg::PMC_SNAP) begin
			addr_q <= system_control_block_i + `PMC_BASE_PTR_OFS;
		end else if (state_q == pmc_pkg::PMC_CHK) begin
			addr_q <= (lw_q & `PMC_BASE_MASK) +
				{20'h00000, processor_number_i, `PMC_CPU_SHIFT};
		end else if (state_q == pmc_pkg::PMC_WRA && mem_ack_i) begin
			addr_q <= addr_q + `PMC_QUAD_STEP;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wdata_q <= 64'h0;
		end else if (state_q == pmc_pkg::PMC_RDA && mem_ack_i) begin
			wdata_q <= mem_rdata_i + {48'h0, snap_a_q};
		end else if (state_q == pmc_pkg::PMC_RDB && mem_ack_i) begin
			wdata_q <= mem_rdata_i + {48'h0, snap_b_q};
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mchk_q <= 1'b0;
		end else begin
			mchk_q <= state_q == pmc_pkg::PMC_CHK && !cfg_ok;
		end
	end

	// ---------------------------------------------------------------
	// facility enable
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			facility_on_q <= 1'b0;
		end else if (done && cause_irq_q) begin
			facility_on_q <= 1'b1;
		end else if (go) begin
			facility_on_q <= 1'b0;
		end else if (me_wr_i) begin
			facility_on_q <= me_wdata_i;
		end else if (exec_control_reg_wr_i) begin
			facility_on_q <= exec_control_reg_on_i;
		end
	end

	// ---------------------------------------------------------------
	// interrupt request
	// ---------------------------------------------------------------
	assign irq_set = cif.half && !half_q && facility_on_q;
	assign irq_clr = counter_clear_bit_i || (done && cause_irq_q);

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			half_q <= 1'b0;
		end else begin
			half_q <= cif.half;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_q <= 1'b0;
		end else if (irq_set) begin
			irq_q <= 1'b1;
		end else if (irq_clr) begin
			irq_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign cif.count_en = facility_on_q && state_q == pmc_pkg::PMC_IDLE;
	assign cif.clear = counter_clear_bit_i ||
		state_q == pmc_pkg::PMC_SNAP;
	assign counter_readout_reg_o = {cif.cnt_b, cif.cnt_a};
	assign facility_on_o = facility_on_q;
	assign irq_o = irq_q;
	assign irq_level_o = `PMC_IRQ_LEVEL;
	assign busy_o = state_q != pmc_pkg::PMC_IDLE;
	assign mchk_o = mchk_q;
	assign mchk_code_o = `PMC_CFG_FAULT_CODE;
	assign mem_req_o = state_q == pmc_pkg::PMC_BASE ||
		state_q == pmc_pkg::PMC_RDA || state_q == pmc_pkg::PMC_WRA ||
		state_q == pmc_pkg::PMC_RDB || state_q == pmc_pkg::PMC_WRB;
	assign mem_we_o = state_q == pmc_pkg::PMC_WRA ||
		state_q == pmc_pkg::PMC_WRB;
	assign mem_addr_o = addr_q;
	assign mem_wdata_o = wdata_q;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	svc_priority_a: assert property (
		state_q == pmc_pkg::PMC_SNAP && cause_irq_q
		|-> $past(priority_level_i) < `PMC_IRQ_LEVEL)
		else $error("service started at too high a priority");
	svc_boundary_a: assert property (
		state_q == pmc_pkg::PMC_IDLE ##1 state_q == pmc_pkg::PMC_SNAP &&
		cause_irq_q |-> $past(instr_boundary_i))
		else $error("service started off an instruction boundary");
	snap_clear_a: assert property (
		state_q == pmc_pkg::PMC_SNAP |=> cif.cnt_a == 16'h0000 &&
		snap_a_q == $past(cif.cnt_a))
		else $error("counters not snapshot and cleared");
	busy_off_a: assert property (
		busy_o |-> !cif.count_en)
		else $error("counting while updating memory");
	cfg_fault_a: assert property (
		state_q == pmc_pkg::PMC_CHK && !cfg_ok
		|=> mchk_o && state_q == pmc_pkg::PMC_IDLE ##1 !mchk_o)
		else $error("bad configuration not faulted");
	block_addr_a: assert property (
		state_q == pmc_pkg::PMC_RDA |-> mem_addr_o ==
		(lw_q & `PMC_BASE_MASK) + {20'h00000, processor_number_i, 4'h0})
		else $error("wrong per-cpu block address");
	reenable_a: assert property (
		done && cause_irq_q |=> facility_on_q && !irq_q)
		else $error("facility not re-enabled after service");
	direct_off_a: assert property (
		exec_control_reg_wr_i && !exec_control_reg_on_i && !me_wr_i &&
		!go && !counter_clear_bit_i && state_q == pmc_pkg::PMC_IDLE
		|=> !facility_on_q && state_q == pmc_pkg::PMC_IDLE &&
		cif.cnt_a == $past(cif.cnt_a) + 16'($past(cif.inc_a) &&
		$past(cif.count_en) && $past(cif.cnt_a) != `PMC_CNT_MAX))
		else $error("direct disable touched counters or memory");
	clear_irq_a: assert property (
		counter_clear_bit_i && !irq_set |=> !irq_q && cif.cnt_b == 16'h0000)
		else $error("clear bit left state behind");
	flush_go_a: assert property (
		state_q == pmc_pkg::PMC_IDLE && flush_go |=> state_q ==
		pmc_pkg::PMC_SNAP && !facility_on_q)
		else $error("disable did not start a memory update");

	irq_service_c: cover property (
		go && irq_go ##[1:40] done && cause_irq_q);
	cfg_fault_c: cover property (mchk_o);
	ctx_flush_c: cover property (
		go && flush_go && ctx_load_i ##[1:40] state_q == pmc_pkg::PMC_WRB);
endmodule
